// >>> pkg/dcsm_pkg.sv
// Purpose: Shared constants and types of the dual channel speed monitor
// Assumes: 125 MHz system clock
// Notes:   Object indices are the measured and peak frequency objects
package dcsm_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int          CLK_HZ        = 125000000;
	localparam int          GATE_TIME_MS  = 1000;
	localparam int          GATE_CYCLES   = (CLK_HZ / 1000) * GATE_TIME_MS;

	////////////////////////////////////////////////////////////////////////
	// Frequency range, in hertz and in reported units
	localparam int          FREQ_MIN_HZ   = 2;
	localparam int          FREQ_MAX_HZ   = 500;
	localparam logic [15:0] TENTHS_PER_HZ = 16'h000a;
	localparam int          EDGE_W        = 10;

	////////////////////////////////////////////////////////////////////////
	// Objects reached over the object port
	localparam logic [15:0] OBJ_FREQ_INDEX = 16'ha008;
	localparam logic [15:0] OBJ_PEAK_INDEX = 16'ha009;
	localparam logic [7:0]  OBJ_SUB_FIRST  = 8'h01;
	localparam logic [15:0] FREQ_RESET     = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// Process image
	localparam int          IMAGE_BYTES   = 6;
	localparam int          ACK_BIT       = 0;
	localparam int          CHANNELS      = 8;
	localparam int          PAIRS         = 4;

	////////////////////////////////////////////////////////////////////////
	// Pair modes
	typedef enum logic [1:0] {
		DCSM_SYNC    = 2'h0,
		DCSM_ENCODER = 2'h1,
		DCSM_ASYNC   = 2'h2
	} dcsm_mode_e;

	////////////////////////////////////////////////////////////////////////
	// Device run state
	typedef enum logic [2:0] {
		DCSM_BOOT = 3'h1,
		DCSM_RUN  = 3'h2,
		DCSM_FAIL = 3'h4
	} dcsm_state_e;

endpackage : dcsm_pkg

// >>> rtl/dcsm_speed_monitor.sv
// Purpose: Eight channel frequency measurement and speed limit monitor
// Assumes: Inputs arrive asynchronously; frames are pulses on clk
// Notes:   Gate time is one second, so resolution is 1 Hz in 0.1 Hz units
`timescale 1ns/10ps

// How it works
// - Sync mode: both inputs low is pair error
// - Sync/encoder: output high while frequency below limit
// - Encoder mode: every input state is accepted
// - Async mode: both outputs high when both below
// - Below 2 Hz the frequency reads zero
// - Above 500 Hz sets overspeed diagnostic
// - Acknowledge rising edge clears the diagnostic
// - Six byte image in each direction
// - Input image carries channels, output byte ack
// - Run indicator green after fault free startup
// - Run indicator red on any fault
// - Measured frequency readable per channel, 0.1 Hz
// - Peak frequency kept since communication start
// - Writing a frequency or peak object forces fail stop
module dcsm_speed_monitor #(
	parameter int GATE_CYCLES = dcsm_pkg::GATE_CYCLES
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Safe input pins
	input  wire logic [7:0]  inPin,
	// Configuration
	input  wire logic [7:0]  pairMode,
	input  wire logic [127:0] speedLimit,
	// Safety frames
	input  wire logic        frameValid,
	input  wire logic [47:0] outImage,
	input  wire logic        commStart,
	output logic      [47:0] inImage,
	// Object access
	input  wire logic        objReq,
	input  wire logic        objWr,
	input  wire logic [15:0] objIndex,
	input  wire logic [7:0]  objSub,
	output logic      [15:0] objRdata,
	output logic             objAck,
	// Status
	output logic      [7:0]  chanResult,
	output logic      [7:0]  overspeed,
	output logic      [3:0]  pairError,
	output logic             ledGreen,
	output logic             ledRed
);

	localparam int          CH = dcsm_pkg::CHANNELS;
	localparam int          EW = dcsm_pkg::EDGE_W;
	localparam logic [EW-1:0] EDGE_MAX = '1;
	localparam logic [EW-1:0] EDGE_MIN = EW'(dcsm_pkg::FREQ_MIN_HZ);
	localparam logic [EW-1:0] EDGE_TOP = EW'(dcsm_pkg::FREQ_MAX_HZ);
	localparam logic [31:0] GATE_LAST = 32'(GATE_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers and edge detection
	logic [7:0] pinMeta;
	logic [7:0] pinSync;
	logic [7:0] pinPrev;
	logic [7:0] pinRise;
	logic [2:0] pinFill;

	// Flops hold reset values, not pin data, until the chain has filled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinMeta <= 8'h00;
			pinSync <= 8'h00;
			pinPrev <= 8'h00;
			pinFill <= 3'h0;
		end else begin
			pinMeta <= inPin;
			pinSync <= pinMeta;
			pinPrev <= pinSync;
			pinFill <= {pinFill[1:0], 1'b1};
		end
	end

	assign pinRise = pinSync & ~pinPrev & {8{pinFill[2]}};

	////////////////////////////////////////////////////////////////////////
	// Measurement, diagnostics and run state
	logic [31:0]   gateCnt;
	logic [31:0]   next_gateCnt;
	logic [EW-1:0] edgeCnt [CH];
	logic [EW-1:0] next_edgeCnt [CH];
	logic [15:0]   freq [CH];
	logic [15:0]   next_freq [CH];
	logic [15:0]   peak [CH];
	logic [15:0]   next_peak [CH];
	logic [7:0]    next_overspeed;
	logic [3:0]    next_pairError;
	logic [7:0]    next_chanResult;
	logic          ackPrev;
	logic          next_ackPrev;
	logic          ackRise;
	logic          gateEnd;
	logic          diagWrite;
	logic          fault;
	logic [7:0]    below;
	dcsm_pkg::dcsm_state_e state;
	dcsm_pkg::dcsm_state_e next_state;

	always_comb begin
		gateEnd      = (gateCnt == GATE_LAST);
		next_gateCnt = gateEnd ? 32'h0 : gateCnt + 32'h1;
		// Acknowledge sampled once per frame
		ackRise      = frameValid && outImage[dcsm_pkg::ACK_BIT]
			&& !ackPrev;
		next_ackPrev = frameValid ? outImage[dcsm_pkg::ACK_BIT] : ackPrev;
		diagWrite    = objReq && objWr
			&& (objIndex == dcsm_pkg::OBJ_FREQ_INDEX
			|| objIndex == dcsm_pkg::OBJ_PEAK_INDEX);
		for (int i = 0; i < CH; i++) begin
			next_edgeCnt[i] = edgeCnt[i];
			next_freq[i]    = freq[i];
			if (gateEnd) begin
				next_edgeCnt[i] = '0;
				if (edgeCnt[i] < EDGE_MIN) begin
					next_freq[i] = dcsm_pkg::FREQ_RESET;
				end else begin
					next_freq[i] = 16'(edgeCnt[i])
						* dcsm_pkg::TENTHS_PER_HZ;
				end
			end else if (pinRise[i] && edgeCnt[i] != EDGE_MAX) begin
				next_edgeCnt[i] = edgeCnt[i] + EW'(1);
			end
			// Restart of communication restarts the peak
			if (commStart) begin
				next_peak[i] = dcsm_pkg::FREQ_RESET;
			end else if (freq[i] > peak[i]) begin
				next_peak[i] = freq[i];
			end else begin
				next_peak[i] = peak[i];
			end
			// Set wins over acknowledge
			next_overspeed[i] = (overspeed[i] && !ackRise)
				|| (gateEnd && edgeCnt[i] > EDGE_TOP);
			below[i] = freq[i] < speedLimit[16*i +: 16];
		end
		for (int p = 0; p < dcsm_pkg::PAIRS; p++) begin
			next_pairError[p] = pairError[p] && !ackRise;
			case (dcsm_pkg::dcsm_mode_e'(pairMode[2*p +: 2]))
				dcsm_pkg::DCSM_SYNC: begin
					if (pinFill[1] && !pinSync[2*p]
						&& !pinSync[2*p+1]) begin
						next_pairError[p] = 1'b1;
					end
					next_chanResult[2*p]   = below[2*p];
					next_chanResult[2*p+1] = below[2*p+1];
				end
				dcsm_pkg::DCSM_ENCODER: begin
					next_chanResult[2*p]   = below[2*p];
					next_chanResult[2*p+1] = below[2*p+1];
				end
				default: begin
					next_chanResult[2*p]   = below[2*p]
						&& below[2*p+1];
					next_chanResult[2*p+1] = below[2*p]
						&& below[2*p+1];
				end
			endcase
			if (next_pairError[p] || overspeed[2*p] || overspeed[2*p+1]) begin
				next_chanResult[2*p]   = 1'b0;
				next_chanResult[2*p+1] = 1'b0;
			end
		end
		case (state)
			dcsm_pkg::DCSM_BOOT: next_state = dcsm_pkg::DCSM_RUN;
			dcsm_pkg::DCSM_RUN:  next_state = dcsm_pkg::DCSM_RUN;
			dcsm_pkg::DCSM_FAIL: next_state = dcsm_pkg::DCSM_FAIL;
			default:             next_state = dcsm_pkg::DCSM_FAIL;
		endcase
		if (diagWrite) begin
			next_state = dcsm_pkg::DCSM_FAIL;
		end
		if (next_state != dcsm_pkg::DCSM_RUN) begin
			next_chanResult = 8'h00;
		end
		fault = (|next_overspeed) || (|next_pairError)
			|| next_state == dcsm_pkg::DCSM_FAIL;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gateCnt    <= 32'h0;
			ackPrev    <= 1'b0;
			overspeed  <= 8'h00;
			pairError  <= 4'h0;
			chanResult <= 8'h00;
			state      <= dcsm_pkg::DCSM_BOOT;
			ledGreen   <= 1'b0;
			ledRed     <= 1'b0;
			inImage    <= 48'h0;
			for (int i = 0; i < CH; i++) begin
				edgeCnt[i] <= '0;
				freq[i]    <= dcsm_pkg::FREQ_RESET;
				peak[i]    <= dcsm_pkg::FREQ_RESET;
			end
		end else begin
			gateCnt    <= next_gateCnt;
			ackPrev    <= next_ackPrev;
			overspeed  <= next_overspeed;
			pairError  <= next_pairError;
			chanResult <= next_chanResult;
			state      <= next_state;
			ledGreen   <= next_state == dcsm_pkg::DCSM_RUN && !fault;
			ledRed     <= fault;
			inImage    <= {40'h0, next_chanResult};
			edgeCnt    <= next_edgeCnt;
			freq       <= next_freq;
			peak       <= next_peak;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Object read port
	logic [15:0] next_objRdata;
	logic [7:0]  subIdx;

	always_comb begin
		subIdx        = objSub - dcsm_pkg::OBJ_SUB_FIRST;
		next_objRdata = 16'h0000;
		if (objReq && !objWr && subIdx < 8'(CH)) begin
			if (objIndex == dcsm_pkg::OBJ_FREQ_INDEX) begin
				next_objRdata = freq[subIdx[2:0]];
			end else if (objIndex == dcsm_pkg::OBJ_PEAK_INDEX) begin
				next_objRdata = peak[subIdx[2:0]];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			objRdata <= 16'h0000;
			objAck   <= 1'b0;
		end else begin
			objRdata <= next_objRdata;
			objAck   <= objReq;
		end
	end

endmodule : dcsm_speed_monitor

// >>> testbench/dcsm_partner.sv
// Purpose: Safety controller sending frames every 16 cycles
// Assumes: Image bit 0 is the acknowledge
// Notes:   Image is scrambled between frames
`timescale 1ns/10ps
module dcsm_partner (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ackLevel,
	input  wire logic        restart,
	output logic             frameValid,
	output logic      [47:0] outImage,
	output logic             commStart
);
	logic [3:0] tick;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick       <= 4'h0;
			frameValid <= 1'b0;
			outImage   <= 48'h0;
			commStart  <= 1'b0;
		end else begin
			tick       <= tick + 4'h1;
			frameValid <= tick == 4'hf;
			outImage   <= {47'h0, ackLevel ^ (tick != 4'hf)};
			commStart  <= restart;
		end
	end
endmodule : dcsm_partner

// >>> testbench/dcsm_speed_monitor_properties.sv
// Purpose: Port assertions of the speed monitor
// Assumes: One clock, registered outputs
// Notes:   Bound to the top module
`timescale 1ns/10ps
module dcsm_props (
	// Watched ports
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        frameValid,
	input wire logic        objReq,
	input wire logic        objWr,
	input wire logic [15:0] objIndex,
	input wire logic        objAck,
	input wire logic [47:0] inImage,
	input wire logic [7:0]  chanResult,
	input wire logic [7:0]  overspeed,
	input wire logic [3:0]  pairError,
	input wire logic        ledGreen,
	input wire logic        ledRed
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wr;
		objReq && objWr && objIndex[15:1] == 15'h5004;
	endsequence
	sequence s_stop;
		ledRed && !ledGreen && chanResult == 8'h00;
	endsequence
	property p_fail; s_wr |-> ##2 s_stop [*8]; endproperty
	property p_ack; objReq |=> objAck; endproperty
	property p_img; inImage == {40'h0, chanResult}; endproperty
	property p_led; ledGreen |-> !ledRed; endproperty
	property p_red;
		(|overspeed) && $past(|overspeed) |-> ledRed && !ledGreen;
	endproperty
	property p_stick; (|overspeed) && !frameValid |=> |overspeed; endproperty
	property p_ovOut;
		(|overspeed[5:4]) && $past(|overspeed[5:4]) |-> chanResult[5:4] == 2'h0;
	endproperty
	property p_pair;
		pairError[1] && $past(pairError[1]) |-> chanResult[3:2] == 2'h0;
	endproperty
	a_fail: assert property (p_fail) else $error("no fail stop");
	a_ack: assert property (p_ack) else $error("no ack");
	a_img: assert property (p_img) else $error("image wrong");
	a_led: assert property (p_led) else $error("both leds");
	a_red: assert property (p_red) else $error("led not red");
	a_stick: assert property (p_stick) else $error("lost flag");
	a_ovOut: assert property (p_ovOut) else $error("pair not off");
	a_pair: assert property (p_pair) else $error("pair error open");
endmodule : dcsm_props
bind dcsm_speed_monitor dcsm_props i_dcsm_props (.clk, .rst, .frameValid,
	.objReq, .objWr, .objIndex, .objAck, .inImage, .chanResult, .overspeed,
	.pairError, .ledGreen, .ledRed);

// >>> testbench/tb_top.sv
// Purpose: Self checking bench of the speed monitor
// Assumes: Short gate of 1200 cycles
// Notes:   Fail stop is entered last
`timescale 1ns/10ps
module tb_top;
	localparam int G = 1200;
	logic         clk, rst, frameValid, commStart, objReq, objWr, objAck;
	logic         ledGreen, ledRed, ackLevel, restart;
	logic [7:0]   inPin, pairMode, objSub, chanResult, overspeed;
	logic [3:0]   pairError;
	logic [127:0] speedLimit;
	logic [47:0]  outImage, inImage;
	logic [15:0]  objIndex, objRdata, rd, lim[8];
	int           miscompares, checked, cyc, h[8], cnt[8];
	dcsm_speed_monitor #(.GATE_CYCLES(G)) i_dcsm_speed_monitor (.clk, .rst,
		.inPin, .pairMode, .speedLimit, .frameValid, .outImage, .commStart,
		.inImage, .objReq, .objWr, .objIndex, .objSub, .objRdata, .objAck,
		.chanResult, .overspeed, .pairError, .ledGreen, .ledRed);
	dcsm_partner i_dcsm_partner (.clk, .rst, .ackLevel, .restart,
		.frameValid, .outImage, .commStart);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
		for (int i = 0; i < 8; i++)
			if (h[i] == 0)
				inPin[i] <= 1'b0;
			else if (cnt[i] >= h[i] - 1) begin
				cnt[i]   <= 0;
				inPin[i] <= ~inPin[i];
			end else
				cnt[i] <= cnt[i] + 1;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic close_out();
		if (miscompares == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] got, exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic obj(input logic w, input logic [15:0] x, input int s);
		@(posedge clk);
		objReq   <= 1'b1;
		objWr    <= w;
		objIndex <= x;
		objSub   <= 8'(s);
		@(posedge clk);
		objReq <= 1'b0;
		#1;
		rd = objRdata;
		chk({15'h0, objAck}, 16'h1);
	endtask : obj
	function automatic logic [15:0] expF(int i);
		return (h[i] == 0) ? 16'h0 : 16'(10 * (G / (2 * h[i])));
	endfunction : expF
	function automatic logic [7:0] expRes();
		logic [7:0] b;
		for (int i = 0; i < 8; i++)
			b[i] = expF(i) < lim[i];
		for (int p = 0; p < 4; p++)
			if (pairMode[2*p+1])
				b[2*p+:2] = {2{&b[2*p+:2]}};
		return b;
	endfunction : expRes
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	initial begin
		{rst, objReq, objWr, ackLevel, restart, inPin} = 13'h1008;
		{objIndex, objSub, speedLimit} = '0;
		pairMode = 8'ha9;
		void'($urandom(77010));
		for (int i = 0; i < 8; i++)
			h[i] = 10 + $urandom % 31;
		h[1] = h[0];
		h[3] = h[2];
		h[7] = 700;
		for (int i = 0; i < 8; i++)
			lim[i] = ($urandom % 2) ? expF(i) * 16'h2 + 16'h10 : expF(i) / 16'h2;
		lim[3] = lim[2];
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++)
			speedLimit[16*i+:16] <= lim[i];
		wt(2);
		chk({14'h0, ledGreen, ledRed}, 16'h2);
		wt(3 * G + 20);
		for (int i = 0; i < 8; i++) begin
			obj(1'b0, dcsm_pkg::OBJ_FREQ_INDEX, i + 1);
			chk({15'h0, rd + 16'ha - expF(i) <= 16'h14}, 16'h1);
		end
		chk(rd, 16'h0);
		chk({8'h0, chanResult}, {8'h0, expRes()});
		chk({12'h0, pairError}, 16'h0);
		h[4] = 1;
		wt(2 * G + 20);
		h[4] = 0;
		chk({8'h0, overspeed}, 16'h10);
		chk({14'h0, ledRed, |chanResult[5:4]}, 16'h2);
		obj(1'b0, dcsm_pkg::OBJ_PEAK_INDEX, 5);
		chk({15'h0, rd >= 16'h1388}, 16'h1);
		wt(2 * G);
		chk({8'h0, overspeed}, 16'h10);
		@(posedge clk);
		ackLevel <= 1'b1;
		wt(40);
		chk({7'h0, ledGreen, overspeed}, 16'h100);
		@(posedge clk);
		restart <= 1'b1;
		@(posedge clk);
		restart <= 1'b0;
		wt(G + 20);
		obj(1'b0, dcsm_pkg::OBJ_PEAK_INDEX, 5);
		chk(rd, 16'h0);
		@(posedge clk);
		pairMode <= 8'ha1;
		wt(20);
		chk({12'h0, pairError}, 16'h0);
		chk({8'h0, chanResult}, {8'h0, expRes()});
		{h[2], h[3]} = '0;
		wt(20);
		chk({12'h0, pairError}, 16'h2);
		obj(1'b0, 16'h1234, 1);
		chk(rd, 16'h0);
		obj(1'b1, dcsm_pkg::OBJ_FREQ_INDEX, 1);
		wt(3);
		chk({6'h0, ledGreen, ledRed, chanResult}, 16'h100);
		close_out();
	end
endmodule : tb_top
